//--- common/sif_defines.vh
// constants for the storage-immediate opcode decode sequence
`ifndef SIF_DEFINES_VH
`define SIF_DEFINES_VH

// ************************************************************
// auxiliary save positions, printed numbers and array indexes
// ************************************************************
`define SIF_AUX_POS_OP       8'h00
`define SIF_AUX_POS_BYTE2    8'h01
`define SIF_AUX_POS_NSI_HI   8'h30
`define SIF_AUX_POS_NSI_LO   8'h31
`define SIF_AUX_IDX_OP       2'h0
`define SIF_AUX_IDX_BYTE2    2'h1
`define SIF_AUX_IDX_NSI_HI   2'h2
`define SIF_AUX_IDX_NSI_LO   2'h3
`define SIF_AUX_ENTRIES      4

// ************************************************************
// error indicator codes
// ************************************************************
`define SIF_ERR_NONE         4'h0
`define SIF_ERR_INVALID_OP   4'h1
`define SIF_ERR_PROTECT      4'h4
`define SIF_ERR_ADDRESS      4'h5
`define SIF_ERR_SPEC         4'h6

// ************************************************************
// opcode halves and fixed opcodes
// ************************************************************
`define SIF_UPPER_IMM        4'h9
`define SIF_UPPER_CTRL       4'h8
`define SIF_UPPER_BAD_A      4'hA
`define SIF_UPPER_BAD_B      4'hB
`define SIF_LOWER_DIAG       4'h3
`define SIF_LOWER_PSW        4'h1
`define SIF_OP_STORE_HALF    8'h40
`define SIF_OP_DIAG          8'h83
`define SIF_OP_STATUS_LOAD   8'h81

// ************************************************************
// address checks
// ************************************************************
`define SIF_PROTECT_LIMIT    16'h0090
`define SIF_LIMIT_4K         4'h0
`define SIF_LIMIT_8K         4'h1
`define SIF_LIMIT_16K        4'h2
`define SIF_SIZE_4K          2'h0
`define SIF_SIZE_8K          2'h1
`define SIF_INSTR_STEP       16'h0002
`define SIF_BYTE_STEP        16'h0001

`endif

//--- core/sif_aux_store.v
// auxiliary save positions held in flip-flops
`timescale 1ns/1ps
`include "sif_defines.vh"

module sif_aux_store (
  clk,
  sys_rst,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  input  wire       clk;      // processor clock
  input  wire       sys_rst;  // synchronous reset
  input  wire       wr_en;    // write strobe
  input  wire [1:0] wr_idx;   // entry written
  input  wire [7:0] wr_data;  // byte written
  input  wire [1:0] rd_idx;   // entry read
  output wire [7:0] rd_data;  // byte read, straight from flops

  // ************************************************************
  // storage entries
  // ************************************************************
  wire [7:0] entry_q [0:`SIF_AUX_ENTRIES-1];

  genvar gi;
  generate
    for (gi = 0; gi < `SIF_AUX_ENTRIES; gi = gi + 1) begin : g_ent
      reg [7:0] val_q;  // one save position
      // load on a matching write, clear on reset
      always @(posedge clk) begin
        if (sys_rst) begin
          val_q <= 8'h00;
        end else if (wr_en && (wr_idx == gi[1:0])) begin
          val_q <= wr_data;
        end
      end
      assign entry_q[gi] = val_q;
    end
  endgenerate

  // read is a plain mux, so a write shows one cycle later
  assign rd_data = entry_q[rd_idx];
endmodule

//--- core/sif_decoder.v
// storage-immediate format instruction-phase opcode decoder
`timescale 1ns/1ps
`include "sif_defines.vh"

// Operation
// RULE1: store-halfword: odd operand address stops code 6
// RULE2: save opcode and byte two at positions 00/01
// RULE3: fetch bytes three, four; next address remains
// RULE4: base 8-bit set adds register to displacement
// RULE5: top address nibble within storage size limit
// RULE6: over limit stops with address code 5
// RULE7: store next address at positions 30/31
// RULE8: read opcode, split halves, lower to nibble
// RULE9: upper half A or B stops code 1
// RULE10: upper 9 immediate path, 8 control path
// RULE11: immediate path keeps byte two for execution
// RULE12: nibble, operand address, byte two placed
// RULE13: lower 8-bit clear, below 144 stops 4
// RULE14: decode 91,92,94,95,96; others stop code 1
// RULE15: 8-bit and 4-bit set stops code 1
// RULE16: decode 99..9B; 98 invalid, no protect check
// RULE17: control lower half 3 starts diagnostic 83
// RULE18: control other than 3 or 1 stops
// RULE19: lower 1: protect check, then status load 81
// RULE20: storage-to-storage fetches, indexes first operand
// RULE21: error stop holds code until reset or restart

module sif_decoder (
  clk,
  sys_rst,
  start_si,
  start_ss,
  start_sth,
  instr_addr,
  opcode_in,
  byte2_in,
  op2_addr_in,
  storage_size,
  operator_restart,
  mem_rd_req,
  mem_rd_addr,
  mem_rd_data,
  mem_rd_ack,
  gr_sel,
  gr_data,
  exec_start,
  exec_opcode,
  ss_op1_ready,
  busy,
  cpu_stopped,
  error_indicator_reg,
  decode_nibble_reg,
  upper_half_reg,
  lower_half_reg,
  address_high_reg,
  address_mid_reg,
  address_low_reg,
  address_lowest_reg,
  sub_addr
);
  input  wire        clk;                 // 40 MHz processor clock
  input  wire        sys_rst;             // synchronous reset
  input  wire        start_si;            // begin storage-immediate decode
  input  wire        start_ss;            // begin storage-to-storage decode
  input  wire        start_sth;           // store-halfword boundary check
  input  wire [15:0] instr_addr;          // address of the opcode byte
  input  wire [7:0]  opcode_in;           // instruction byte one
  input  wire [7:0]  byte2_in;            // instruction byte two
  input  wire [15:0] op2_addr_in;         // operand 2 for store-halfword
  input  wire [1:0]  storage_size;        // 0 4K, 1 8K, else 16K
  input  wire        operator_restart;    // clears an error stop
  output reg         mem_rd_req;          // main storage read request
  output reg  [15:0] mem_rd_addr;         // main storage byte address
  input  wire [7:0]  mem_rd_data;         // byte returned
  input  wire        mem_rd_ack;          // read completes this cycle
  output reg  [2:0]  gr_sel;              // general register selected
  input  wire [15:0] gr_data;             // general register contents
  output reg         exec_start;          // one-cycle execution start
  output reg  [7:0]  exec_opcode;         // opcode decoded
  output reg         ss_op1_ready;        // one-cycle, first operand done
  output wire        busy;                // sequence in progress
  output reg         cpu_stopped;         // error stop held
  output reg  [3:0]  error_indicator_reg; // error code
  output reg  [3:0]  decode_nibble_reg;   // nibble under decode
  output reg  [3:0]  upper_half_reg;      // opcode upper half
  output reg  [3:0]  lower_half_reg;      // opcode lower half
  output wire [3:0]  address_high_reg;    // address bits 15..12
  output wire [3:0]  address_mid_reg;     // address bits 11..8
  output wire [3:0]  address_low_reg;     // address bits 7..4
  output wire [3:0]  address_lowest_reg;  // address bits 3..0
  output reg  [15:0] sub_addr;            // sub-register contents

  // ************************************************************
  // sequencer states
  // ************************************************************
  localparam [3:0] S_IDLE   = 4'h0;  // waiting for a start
  localparam [3:0] S_SAVE1  = 4'h1;  // byte two to position 01
  localparam [3:0] S_FETCH3 = 4'h2;  // base and high displacement
  localparam [3:0] S_FETCH4 = 4'h3;  // low displacement
  localparam [3:0] S_INDEX  = 4'h4;  // optional register add
  localparam [3:0] S_CHKSZ  = 4'h5;  // storage size check
  localparam [3:0] S_NSI_HI = 4'h6;  // next address high byte
  localparam [3:0] S_NSI_LO = 4'h7;  // next address low byte
  localparam [3:0] S_READOP = 4'h8;  // opcode back from position 00
  localparam [3:0] S_UPPER  = 4'h9;  // upper half decode
  localparam [3:0] S_IMM    = 4'hA;  // byte two back from position 01
  localparam [3:0] S_LOWER  = 4'hB;  // immediate lower half decode
  localparam [3:0] S_STOP   = 4'hC;  // error stop

  reg  [3:0]  state_q;     // current step
  reg  [15:0] addr_q;      // address registers as one word
  reg         ss_mode_q;   // storage-to-storage sequence
  reg  [7:0]  byte2_q;     // byte two until it is saved
  reg         aux_wr_en;   // save position write
  reg  [1:0]  aux_wr_idx;  // position written
  reg  [7:0]  aux_wr_data; // byte written
  reg  [1:0]  aux_rd_idx;  // position read
  wire [7:0]  aux_rd_data; // byte read back
  reg  [3:0]  size_limit;  // top nibble ceiling
  wire        below_prot;  // operand inside protected area

  assign address_high_reg   = addr_q[15:12];
  assign address_mid_reg    = addr_q[11:8];
  assign address_low_reg    = addr_q[7:4];
  assign address_lowest_reg = addr_q[3:0];
  assign busy               = (state_q != S_IDLE) && (state_q != S_STOP);
  assign below_prot         = (addr_q < `SIF_PROTECT_LIMIT);

  // ************************************************************
  // save positions
  // ************************************************************
  sif_aux_store u_aux (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (aux_wr_en),
    .wr_idx  (aux_wr_idx),
    .wr_data (aux_wr_data),
    .rd_idx  (aux_rd_idx),
    .rd_data (aux_rd_data)
  );

  // storage size selects the highest legal top nibble
  always @* begin
    case (storage_size)
      `SIF_SIZE_4K: size_limit = `SIF_LIMIT_4K;
      `SIF_SIZE_8K: size_limit = `SIF_LIMIT_8K;
      default:      size_limit = `SIF_LIMIT_16K;
    endcase
  end

  // save position writes and read selection per step
  always @* begin
    aux_wr_en   = 1'b0;
    aux_wr_idx  = `SIF_AUX_IDX_OP;
    aux_wr_data = 8'h00;
    aux_rd_idx  = `SIF_AUX_IDX_OP;
    case (state_q)
      S_IDLE: begin
        // opcode is written the cycle a start is taken
        aux_wr_en   = (start_si | start_ss) & ~start_sth; // RULE2
        aux_wr_data = opcode_in;
      end
      S_SAVE1: begin
        aux_wr_en   = 1'b1;                        // RULE2
        aux_wr_idx  = `SIF_AUX_IDX_BYTE2;
        aux_wr_data = byte2_q;
      end
      S_NSI_HI: begin
        aux_wr_en   = 1'b1;                        // RULE7
        aux_wr_idx  = `SIF_AUX_IDX_NSI_HI;
        aux_wr_data = sub_addr[15:8];
      end
      S_NSI_LO: begin
        aux_wr_en   = 1'b1;                        // RULE7
        aux_wr_idx  = `SIF_AUX_IDX_NSI_LO;
        aux_wr_data = sub_addr[7:0];
      end
      S_IMM: begin
        aux_rd_idx  = `SIF_AUX_IDX_BYTE2;
      end
      default: begin
        aux_rd_idx  = `SIF_AUX_IDX_OP;
      end
    endcase
  end

  // ************************************************************
  // main sequencer
  // ************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q             <= S_IDLE;
      addr_q              <= 16'h0000;
      sub_addr            <= 16'h0000;
      ss_mode_q           <= 1'b0;
      byte2_q             <= 8'h00;
      mem_rd_req          <= 1'b0;
      mem_rd_addr         <= 16'h0000;
      gr_sel              <= 3'h0;
      exec_start          <= 1'b0;
      exec_opcode         <= 8'h00;
      ss_op1_ready        <= 1'b0;
      cpu_stopped         <= 1'b0;
      error_indicator_reg <= `SIF_ERR_NONE;
      decode_nibble_reg   <= 4'h0;
      upper_half_reg      <= 4'h0;
      lower_half_reg      <= 4'h0;
    end else begin
      // pulses last one cycle
      exec_start   <= 1'b0;
      ss_op1_ready <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start_sth) begin
            addr_q <= op2_addr_in;
            if (op2_addr_in[0]) begin
              // odd halfword address is a specification stop
              error_indicator_reg <= `SIF_ERR_SPEC;          // RULE1
              cpu_stopped         <= 1'b1;
              state_q             <= S_STOP;
            end else begin
              exec_opcode <= `SIF_OP_STORE_HALF;             // RULE1
              exec_start  <= 1'b1;
            end
          end else if (start_si || start_ss) begin
            ss_mode_q <= start_ss;                           // RULE20
            byte2_q   <= byte2_in;                           // RULE2
            // exchange brings the byte-three address forward
            addr_q    <= instr_addr + `SIF_INSTR_STEP;
            state_q   <= S_SAVE1;
          end
        end
        S_SAVE1: begin
          mem_rd_req  <= 1'b1;                               // RULE3
          mem_rd_addr <= addr_q;
          state_q     <= S_FETCH3;
        end
        S_FETCH3: begin
          if (mem_rd_ack) begin
            decode_nibble_reg <= mem_rd_data[7:4];           // RULE3
            sub_addr[15:8]    <= {4'h0, mem_rd_data[3:0]};
            addr_q            <= addr_q + `SIF_BYTE_STEP;
            mem_rd_addr       <= addr_q + `SIF_BYTE_STEP;
            state_q           <= S_FETCH4;
          end
        end
        S_FETCH4: begin
          if (mem_rd_ack) begin
            mem_rd_req <= 1'b0;
            // exchange: displacement forward, next address aside
            addr_q     <= {sub_addr[15:8], mem_rd_data};     // RULE3
            sub_addr   <= addr_q + `SIF_BYTE_STEP;           // RULE20
            gr_sel     <= decode_nibble_reg[2:0];
            state_q    <= S_INDEX;
          end
        end
        S_INDEX: begin
          // base 8-bit asks for the register to be added
          if (decode_nibble_reg[3]) begin
            addr_q <= addr_q + gr_data;                      // RULE4
          end
          state_q <= S_CHKSZ;
        end
        S_CHKSZ: begin
          if (addr_q[15:12] > size_limit) begin              // RULE5
            error_indicator_reg <= `SIF_ERR_ADDRESS;         // RULE6
            cpu_stopped         <= 1'b1;
            state_q             <= S_STOP;
          end else if (ss_mode_q) begin
            // first operand ready, byte-five address in sub
            ss_op1_ready <= 1'b1;                            // RULE20
            state_q      <= S_IDLE;
          end else begin
            state_q <= S_NSI_HI;
          end
        end
        S_NSI_HI: begin
          state_q <= S_NSI_LO;
        end
        S_NSI_LO: begin
          state_q <= S_READOP;
        end
        S_READOP: begin
          upper_half_reg    <= aux_rd_data[7:4];             // RULE8
          lower_half_reg    <= aux_rd_data[3:0];
          decode_nibble_reg <= aux_rd_data[3:0];             // RULE8
          state_q           <= S_UPPER;
        end
        S_UPPER: begin
          case (upper_half_reg)
            `SIF_UPPER_IMM: begin
              state_q <= S_IMM;                              // RULE10
            end
            `SIF_UPPER_CTRL: begin                           // RULE10
              if (decode_nibble_reg == `SIF_LOWER_DIAG) begin
                exec_opcode <= `SIF_OP_DIAG;                 // RULE17
                exec_start  <= 1'b1;
                state_q     <= S_IDLE;
              end else if (decode_nibble_reg == `SIF_LOWER_PSW) begin
                if (below_prot) begin
                  error_indicator_reg <= `SIF_ERR_PROTECT;   // RULE19
                  cpu_stopped         <= 1'b1;
                  state_q             <= S_STOP;
                end else begin
                  exec_opcode <= `SIF_OP_STATUS_LOAD;        // RULE19
                  exec_start  <= 1'b1;
                  state_q     <= S_IDLE;
                end
              end else begin
                error_indicator_reg <= `SIF_ERR_INVALID_OP;  // RULE18
                cpu_stopped         <= 1'b1;
                state_q             <= S_STOP;
              end
            end
            default: begin
              // A and B halves, and anything not of this format
              error_indicator_reg <= `SIF_ERR_INVALID_OP;    // RULE9
              cpu_stopped         <= 1'b1;
              state_q             <= S_STOP;
            end
          endcase
        end
        S_IMM: begin
          // byte two rides in the low sub-register byte
          sub_addr <= {8'h00, aux_rd_data};                  // RULE11 RULE12
          state_q  <= S_LOWER;
        end
        S_LOWER: begin
          if (!decode_nibble_reg[3]) begin
            if (below_prot) begin
              error_indicator_reg <= `SIF_ERR_PROTECT;       // RULE13
              cpu_stopped         <= 1'b1;
              state_q             <= S_STOP;
            end else begin
              case (decode_nibble_reg[2:0])                  // RULE14
                3'h1, 3'h2, 3'h4, 3'h5, 3'h6: begin
                  exec_opcode <= {`SIF_UPPER_IMM, decode_nibble_reg};
                  exec_start  <= 1'b1;
                  state_q     <= S_IDLE;
                end
                default: begin
                  error_indicator_reg <= `SIF_ERR_INVALID_OP;
                  cpu_stopped         <= 1'b1;
                  state_q             <= S_STOP;
                end
              endcase
            end
          end else if (decode_nibble_reg[2] ||
                       (decode_nibble_reg[1:0] == 2'h0)) begin
            // 4-bit with 8-bit, or 98, is not an opcode here
            error_indicator_reg <= `SIF_ERR_INVALID_OP;      // RULE15 RULE16
            cpu_stopped         <= 1'b1;
            state_q             <= S_STOP;
          end else begin
            // no protect check on this branch
            exec_opcode <= {`SIF_UPPER_IMM, decode_nibble_reg}; // RULE16
            exec_start  <= 1'b1;
            state_q     <= S_IDLE;
          end
        end
        S_STOP: begin
          // code stays until reset or operator restart
          if (operator_restart) begin                        // RULE21
            cpu_stopped         <= 1'b0;
            error_indicator_reg <= `SIF_ERR_NONE;
            state_q             <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

//--- dv/sif_decoder_properties.sv
// port-level concurrent checks for the opcode decoder
`timescale 1ns/1ps

module sif_decoder_props (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        start_sth,
  input wire logic [15:0] op2_addr_in,
  input wire logic [1:0]  storage_size,
  input wire logic        operator_restart,
  input wire logic        mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  input wire logic        mem_rd_ack,
  input wire logic        exec_start,
  input wire logic [7:0]  exec_opcode,
  input wire logic        busy,
  input wire logic        cpu_stopped,
  input wire logic [3:0]  error_indicator_reg,
  input wire logic [3:0]  address_high_reg,
  input wire logic [3:0]  address_mid_reg,
  input wire logic [3:0]  address_low_reg,
  input wire logic [3:0]  address_lowest_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // helpers
  // ****************
  wire [15:0] adr = {address_high_reg, address_mid_reg,
                     address_low_reg, address_lowest_reg}; // operand word
  wire [3:0] lim = (storage_size == 2'h0) ? 4'h0 :
                   (storage_size == 2'h1) ? 4'h1 : 4'h2; // size ceiling
  wire idle = !busy && !cpu_stopped; // start accepted only here
  // ****************
  // properties
  // ****************
  property p_sth;
    start_sth && idle |=> ($past(op2_addr_in[0]) ?
      (cpu_stopped && error_indicator_reg == 4'h6) :
      (exec_start && exec_opcode == 8'h40));
  endproperty
  a_sth: assert property (p_sth) else $error("sth check wrong");
  property p_req_hold;
    mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped");
  property p_next_byte;
    (mem_rd_req && mem_rd_ack) ##1 mem_rd_req |->
      mem_rd_addr == $past(mem_rd_addr) + 16'h0001;
  endproperty
  a_next_byte: assert property (p_next_byte) else $error("bad addr");
  property p_size;
    exec_start && exec_opcode[7:4] == 4'h9 |-> address_high_reg <= lim;
  endproperty
  a_size: assert property (p_size) else $error("size limit");
  property p_upper;
    exec_start |-> exec_opcode[7:4] != 4'hA && exec_opcode[7:4] != 4'hB;
  endproperty
  a_upper: assert property (p_upper) else $error("bad upper ran");
  property p_imm_low;
    exec_start && exec_opcode[7:3] == 5'h12 |->
      adr >= 16'h0090 && exec_opcode[2:0] inside {1, 2, 4, 5, 6};
  endproperty
  a_imm_low: assert property (p_imm_low) else $error("imm low");
  property p_ctrl;
    exec_start && exec_opcode[7:4] == 4'h8 |-> exec_opcode == 8'h83 ||
      (exec_opcode == 8'h81 && adr >= 16'h0090);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl decode");
  property p_hold;
    cpu_stopped && !operator_restart |=>
      cpu_stopped && $stable(error_indicator_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("stop lost");
  property p_restart;
    cpu_stopped && operator_restart |-> ##[1:2] !cpu_stopped;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  c_exec: cover property (exec_start && exec_opcode == 8'h81);
  c_stop: cover property ($rose(cpu_stopped));
  c_sth: cover property (start_sth && idle);
endmodule

bind sif_decoder sif_decoder_props i_props (.*);

//--- dv/sif_mem_model.sv
// behavioural main storage answering the decoder's byte reads
`timescale 1ns/1ps

module sif_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_rd_addr,
  output logic      [7:0]  mem_rd_data,
  output logic             mem_rd_ack
);
  logic [7:0]  mem_q [0:255]; // storage image, low address byte
  logic [3:0]  cnt_q;         // wait cycles spent so far
  logic [15:0] last_q;        // last address answered
  // ****************
  // read answer
  // ****************
  // data line toggles when not acked so stale bytes never look valid
  initial begin
    mem_rd_data = 8'h5A;
    mem_rd_ack = 1'b0;
  end
  always @(posedge clk) begin
    mem_rd_ack <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if (sys_rst || !mem_rd_req || mem_rd_ack) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= wait_cyc) begin
      mem_rd_ack <= 1'b1;
      mem_rd_data <= mem_q[mem_rd_addr[7:0]];
      last_q <= mem_rd_addr;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

//--- dv/tb_top.sv
// self-checking bench for the storage-immediate opcode decoder
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {
    logic [7:0]  op;
    logic [3:0]  base;
    logic [11:0] disp;
    logic [15:0] gr;
    logic [1:0]  sz;
    logic [3:0]  code;
  } sif_row_t; // code 0 means no error stop
  logic clk = 0, sys_rst = 1, start_si = 0, start_ss = 0, start_sth = 0;
  logic restart = 0, ack, req, exec_start, ss_rdy, busy, stopped;
  logic [1:0]  sz = 2'h2;     // storage size
  logic [7:0]  op = 8'h00;    // opcode byte
  logic [7:0]  rdat, exop;
  logic [15:0] op2 = 16'h0000, raddr, sub;
  logic [15:0] gr_file [0:7]; // general registers
  logic [2:0]  gsel;
  logic [3:0]  err, nib, hi, mi, lo, lw, upp, low_h;
  logic [3:0]  wt = 4'h0;     // memory wait
  int err_total = 0, n_checks = 0, cyc = 0;
  sif_row_t rows [0:28] = '{
    '{8'h91,0,12'h200,0,2,0}, '{8'h92,0,12'h200,0,2,0},
    '{8'h94,0,12'h200,0,2,0}, '{8'h95,0,12'h200,0,2,0},
    '{8'h96,0,12'h200,0,2,0}, '{8'h90,0,12'h200,0,2,1},
    '{8'h93,0,12'h200,0,2,1}, '{8'h97,0,12'h200,0,2,1},
    '{8'h91,0,12'h08F,0,2,4}, '{8'h96,0,12'h090,0,2,0},
    '{8'h99,0,12'h050,0,2,0}, '{8'h9A,0,12'h200,0,2,0},
    '{8'h9B,0,12'h200,0,2,0}, '{8'h98,0,12'h200,0,2,1},
    '{8'h9C,0,12'h200,0,2,1}, '{8'h83,0,12'h050,0,2,0},
    '{8'h81,0,12'h090,0,2,0}, '{8'h81,0,12'h08F,0,2,4},
    '{8'h80,0,12'h200,0,2,1}, '{8'h82,0,12'h200,0,2,1},
    '{8'h84,0,12'h200,0,2,1}, '{8'hA0,0,12'h200,0,2,1},
    '{8'hB5,0,12'h200,0,2,1}, '{8'h91,8,12'h200,16'h1000,0,5},
    '{8'h91,9,12'h200,16'h1000,1,0}, '{8'h91,10,12'hF00,16'h1100,1,5},
    '{8'h91,11,12'h200,16'h2000,2,0}, '{8'h91,15,12'hE00,16'h2200,3,5},
    '{8'h95,7,12'hFFF,16'h1000,0,0}};
  sif_mem_model i_mem (.clk(clk), .sys_rst(sys_rst), .wait_cyc(wt),
    .mem_rd_req(req), .mem_rd_addr(raddr), .mem_rd_data(rdat),
    .mem_rd_ack(ack));
  sif_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .start_si(start_si),
    .start_ss(start_ss), .start_sth(start_sth), .instr_addr(16'h0010),
    .opcode_in(op), .byte2_in(~op), .op2_addr_in(op2),
    .storage_size(sz), .operator_restart(restart), .mem_rd_req(req),
    .mem_rd_addr(raddr), .mem_rd_data(rdat), .mem_rd_ack(ack),
    .gr_sel(gsel), .gr_data(gr_file[gsel]), .exec_start(exec_start),
    .exec_opcode(exop), .ss_op1_ready(ss_rdy), .busy(busy),
    .cpu_stopped(stopped), .error_indicator_reg(err),
    .decode_nibble_reg(nib), .upper_half_reg(upp), .lower_half_reg(low_h),
    .address_high_reg(hi), .address_mid_reg(mi), .address_low_reg(lo),
    .address_lowest_reg(lw), .sub_addr(sub));
  // ****************
  // clock and timeout
  // ****************
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      complete_run();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // wait for any completion, bounded
  task automatic wait_done();
    int n;
    n = 0;
    while (exec_start !== 1'b1 && stopped !== 1'b1 && ss_rdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 100) complete_run_late();
    end
  endtask
  task automatic complete_run_late();
    err_total++;
    complete_run();
  endtask
  // stop must hold, refuse a start, then clear on restart
  task automatic stop_chk(logic [3:0] c);
    chk("err_code", c, err);
    repeat (3) @(negedge clk);
    start_si = 1'b1;
    @(negedge clk) start_si = 1'b0;
    chk("err_held", c, err);
    restart = 1'b1;
    @(negedge clk) restart = 1'b0;
    @(negedge clk);
    chk("restarted", 0, stopped);
  endtask
  task automatic run(sif_row_t r, bit ss);
    logic [15:0] a1;
    a1 = (r.base[3] ? r.gr : 16'h0000) + {4'h0, r.disp};
    gr_file[r.base[2:0]] = r.gr;
    sz = r.sz;
    op = r.op;
    i_mem.mem_q[8'h12] = {r.base, r.disp[11:8]};
    i_mem.mem_q[8'h13] = r.disp[7:0];
    if (ss) start_ss = 1'b1;
    else start_si = 1'b1;
    @(negedge clk);
    start_si = 1'b0;
    start_ss = 1'b0;
    wait_done();
    chk("rd_addr", 16'h0013, i_mem.last_q);
    if (r.code != 4'h0) stop_chk(r.code);
    else chk("operand", a1, {hi, mi, lo, lw});
    if (r.code == 4'h0 && ss) chk("byte5", 16'h0014, sub);
    if (r.code == 4'h0 && !ss) begin
      chk("opcode", r.op, exop);
      chk("nibble", r.op[3:0], nib);
      chk("upper", r.op[7:4], upp);
      chk("lower", r.op[3:0], low_h);
      chk("nsi", 16'h0014, {i_dut.u_aux.g_ent[2].val_q,
        i_dut.u_aux.g_ent[3].val_q});
    end
    if (r.code == 4'h0 && r.op[7:4] == 4'h9)
      chk("imm", {8'h00, ~r.op}, sub);
    $display("test op %h done", r.op);
  endtask
  task automatic sth(logic [15:0] a, bit with_si);
    op2 = a;
    op = 8'h40;
    start_sth = 1'b1;
    start_si = with_si;
    @(negedge clk);
    start_sth = 1'b0;
    start_si = 1'b0;
    wait_done();
    if (a[0]) stop_chk(4'h6);
    else chk("sth_op", 16'h0040, exop);
    $display("test sth %h done", a);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    for (int i = 0; i < 8; i++) gr_file[i] = 16'h0000;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    chk("rst_busy", 0, busy);
    chk("rst_err", 0, err);
    for (int p = 0; p < 2; p++) begin
      wt = p ? 4'h3 : 4'h0; // prompt, then slow storage
      foreach (rows[i]) run(rows[i], 1'b0);
    end
    sth(16'h0201, 1'b0);
    sth(16'h0200, 1'b1);
    run('{8'hD2,8,12'h010,16'h0300,2,0}, 1'b1);
    run('{8'hD2,8,12'h010,16'h3000,2,5}, 1'b1);
    start_si = 1'b1; // reset in mid-sequence
    @(negedge clk) start_si = 1'b0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk("mid_rst_busy", 0, busy);
    chk("mid_rst_req", 0, req);
    run(rows[0], 1'b0);
    complete_run();
  end
endmodule
